/* verilog/acs_params.svh */
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define ACS_OFF_RES_LO   3'h0
`define ACS_OFF_RES_HI   3'h1
`define ACS_OFF_CTRL_B   3'h2
`define ACS_OFF_CSR      3'h3
`define ACS_OFF_SEL      3'h4

// ****************************************
// field positions
// ****************************************
`define ACS_CSR_EN       7
`define ACS_CSR_START    6
`define ACS_CSR_AUTO     5
`define ACS_CSR_FLAG     4
`define ACS_CSR_IE       3
`define ACS_CSR_DIV_HI   2
`define ACS_CSR_DIV_LO   0
`define ACS_SEL_REF_HI   7
`define ACS_SEL_REF_LO   6
`define ACS_SEL_CH_HI    3
`define ACS_SEL_CH_LO    0
`define ACS_CTB_LADJ     3
`define ACS_CTB_TS_HI    2
`define ACS_CTB_TS_LO    0

// ****************************************
// reset values and codes
// ****************************************
`define ACS_RST_BYTE     8'h00
`define ACS_CH_GND       4'hc
`define ACS_CH_BANDGAP   4'hd
`define ACS_CH_TEMP      4'he
`define ACS_CH_NONE      4'hf
`define ACS_TS_FREE      3'h0

// ****************************************
// conversion lengths in adc clock cycles
// ****************************************
`define ACS_CYC_NORMAL   13
`define ACS_CYC_LONG     25

`endif

/* verilog/acs_pkg.sv */
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b01,
        ACS_RUN  = 2'b10
    } acs_state_t;

    typedef enum logic [1:0] {
        ACS_REF_SUPPLY   = 2'b00,
        ACS_REF_EXTERNAL = 2'b01,
        ACS_REF_INTERNAL = 2'b10,
        ACS_REF_RESERVED = 2'b11
    } acs_ref_t;

endpackage : acs_pkg

/* verilog/acs_prescaler.sv */
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_prescaler #(
    parameter int CNT_W = 7
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] div_sel_i,
    output logic            tick_o,
    output logic            adc_clk_o
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] last;
    logic             next_tick;
    logic             next_clk;

    // ****************************************
    // division factor minus one
    // ****************************************
    function automatic logic [CNT_W-1:0] div_last(input logic [2:0] sel);
        logic [7:0] f;
        f = (sel <= 3'h1) ? 8'h02 : 8'(8'h01 << sel);
        return CNT_W'(f - 8'h01);
    endfunction : div_last

    always_comb begin
        last      = div_last(div_sel_i);
        next_tick = 1'b0;
        next_cnt  = '0;
        if (run_i) begin
            if (cnt >= last) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
        next_clk = run_i && (next_cnt <= (last >> 1));
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt       <= '0;
            tick_o    <= 1'b0;
            adc_clk_o <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            tick_o    <= next_tick;
            adc_clk_o <= next_clk;
        end
    end

endmodule : acs_prescaler

/* verilog/acs_conv_timer.sv */
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_conv_timer
    import acs_pkg::*;
#(
    parameter int CNT_W = 5
) (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic tick_i,
    input  wire logic start_i,
    input  wire logic long_i,
    input  wire logic abort_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam logic [CNT_W-1:0] LEN_NORMAL = CNT_W'(`ACS_CYC_NORMAL);
    localparam logic [CNT_W-1:0] LEN_LONG   = CNT_W'(`ACS_CYC_LONG);

    acs_state_t       state;
    acs_state_t       next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] next_len;
    logic             next_done;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_len   = len;
        next_done  = 1'b0;
        unique case (state)
            ACS_IDLE: begin
                if (start_i && !abort_i) begin
                    next_state = ACS_RUN;
                    next_cnt   = '0;
                    next_len   = long_i ? LEN_LONG : LEN_NORMAL;
                end
            end
            ACS_RUN: begin
                if (abort_i) begin
                    next_state = ACS_IDLE;
                end else if (tick_i) begin
                    if (cnt == len - CNT_W'(1)) begin
                        next_state = ACS_IDLE;
                        next_done  = 1'b1;
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end
            end
            default: begin
                next_state = ACS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state  <= ACS_IDLE;
            cnt    <= '0;
            len    <= '0;
            done_o <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            len    <= next_len;
            done_o <= next_done;
        end
    end

    assign busy_o = (state == ACS_RUN);

endmodule : acs_conv_timer

/* verilog/acs_top.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_top
    import acs_pkg::*;
#(
    parameter int TRIG_N  = 7,
    parameter int RES_W   = 10,
    parameter int PRE_W   = 7,
    parameter int TIMER_W = 5
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic [2:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [RES_W-1:0]  conv_result_i,
    input  wire logic [TRIG_N-1:0] trig_src_i,
    input  wire logic              irq_ack_i,
    input  wire logic              global_irq_en_i,
    output logic [7:0]             rdata_o,
    output logic                   irq_o,
    output logic                   conv_power_o,
    output logic                   conv_start_o,
    output logic                   long_conv_o,
    output logic                   adc_clk_o,
    output logic [1:0]             ref_sel_o,
    output logic [2:0]             ref_route_o,
    output logic [3:0]             chan_sel_o,
    output logic                   chan_connect_o,
    output logic                   temp_sensor_en_o
);

    // ****************************************
    // state
    // ****************************************
    logic             en;
    logic             auto_trig;
    logic             flag;
    logic             irq_en;
    logic [2:0]       div_sel;
    logic [7:0]       sel_reg;
    logic             ladj;
    logic [2:0]       ts;
    logic [1:0]       ref_app;
    logic [3:0]       chan_app;
    logic             pend_long;
    logic             trig_prev;
    logic             lock;
    logic [RES_W-1:0] result;

    logic             next_en;
    logic             next_auto_trig;
    logic             next_flag;
    logic             next_irq_en;
    logic [2:0]       next_div_sel;
    logic [7:0]       next_sel_reg;
    logic             next_ladj;
    logic [2:0]       next_ts;
    logic [1:0]       next_ref_app;
    logic [3:0]       next_chan_app;
    logic             next_pend_long;
    logic             next_trig_prev;
    logic             next_lock;
    logic [RES_W-1:0] next_result;
    logic [7:0]       next_rdata;
    logic             next_irq;
    logic             next_long;
    logic [2:0]       next_ref_route;
    logic             next_temp_en;
    logic             next_connect;

    logic             wr_csr;
    logic             wr_sel;
    logic             wr_ctb;
    logic             rd_lo;
    logic             rd_hi;
    logic             busy;
    logic             done;
    logic             tick;
    logic             apply;
    logic             ref_change;
    logic             trig_now;
    logic             trig_edge;
    logic             free_restart;
    logic             fire;
    logic [7:0]       res_lo;
    logic [7:0]       res_hi;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        return a == off;
    endfunction : hit

    function automatic logic [2:0] ref_decode(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        unique case (acs_ref_t'(code))
            ACS_REF_SUPPLY:   r = 3'h1;
            ACS_REF_EXTERNAL: r = 3'h2;
            ACS_REF_INTERNAL: r = 3'h4;
            ACS_REF_RESERVED: r = 3'h0;
        endcase
        return r;
    endfunction : ref_decode

    // ****************************************
    // prescaler and conversion timer
    // ****************************************
    acs_prescaler #(
        .CNT_W     (PRE_W)
    ) u_prescaler (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .run_i     (en),
        .div_sel_i (div_sel),
        .tick_o    (tick),
        .adc_clk_o (adc_clk_o)
    );

    acs_conv_timer #(
        .CNT_W     (TIMER_W)
    ) u_timer (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .start_i   (fire),
        .long_i    (pend_long || ref_change || !en),
        .abort_i   (!next_en),
        .busy_o    (busy),
        .done_o    (done)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        wr_csr = wr_i && hit(addr_i, `ACS_OFF_CSR);
        wr_sel = wr_i && hit(addr_i, `ACS_OFF_SEL);
        wr_ctb = wr_i && hit(addr_i, `ACS_OFF_CTRL_B);
        rd_lo  = rd_i && hit(addr_i, `ACS_OFF_RES_LO);
        rd_hi  = rd_i && hit(addr_i, `ACS_OFF_RES_HI);

        next_en        = wr_csr ? wdata_i[`ACS_CSR_EN]   : en;
        next_auto_trig = wr_csr ? wdata_i[`ACS_CSR_AUTO] : auto_trig;
        next_irq_en    = wr_csr ? wdata_i[`ACS_CSR_IE]   : irq_en;
        next_div_sel   = wr_csr ? wdata_i[`ACS_CSR_DIV_HI:`ACS_CSR_DIV_LO] : div_sel;
        next_sel_reg   = wr_sel ? wdata_i : sel_reg;
        next_ladj      = wr_ctb ? wdata_i[`ACS_CTB_LADJ] : ladj;
        next_ts        = wr_ctb ? wdata_i[`ACS_CTB_TS_HI:`ACS_CTB_TS_LO] : ts;
    end

    // ****************************************
    // applied settings
    // ****************************************
    always_comb begin
        // settings reach the analog side only between conversions
        apply         = !busy;
        next_ref_app  = apply ? sel_reg[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO] : ref_app;
        next_chan_app = apply ? sel_reg[`ACS_SEL_CH_HI:`ACS_SEL_CH_LO] : chan_app;
        ref_change    = apply && (sel_reg[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO] != ref_app);
    end

    // ****************************************
    // trigger selection
    // ****************************************
    always_comb begin
        // trigger selection and edge
        trig_now = 1'b0;
        if (ts != `ACS_TS_FREE) begin
            trig_now = trig_src_i[ts - 3'h1];
        end
        next_trig_prev = trig_now;
        trig_edge      = auto_trig && trig_now && !trig_prev;
        free_restart   = auto_trig && (ts == `ACS_TS_FREE) && done;
    end

    // ****************************************
    // conversion start
    // ****************************************
    always_comb begin
        fire = next_en && !busy &&
               ((wr_csr && wdata_i[`ACS_CSR_START]) ||
                trig_edge || free_restart);
    end

    // ****************************************
    // long conversion
    // ****************************************
    always_comb begin
        // long conversion after enable or after reference change
        next_pend_long = (pend_long || ref_change || !en) && !fire;
        next_long      = fire ? (pend_long || ref_change || !en) : long_conv_o;
    end

    // ****************************************
    // done flag and interrupt
    // ****************************************
    always_comb begin
        // done flag: set wins over either clear
        next_flag = done ||
                    (flag && !(wr_csr && wdata_i[`ACS_CSR_FLAG]) && !irq_ack_i);
        next_irq  = next_flag && next_irq_en && global_irq_en_i;
    end

    // ****************************************
    // result lock
    // ****************************************
    always_comb begin
        // result coherence
        next_lock = lock;
        if (rd_lo) begin
            next_lock = 1'b1;
        end else if (rd_hi) begin
            next_lock = 1'b0;
        end
        next_result = (done && !lock) ? conv_result_i : result;
    end

    // ****************************************
    // result presentation
    // ****************************************
    always_comb begin
        // presentation
        if (ladj) begin
            res_hi = result[RES_W-1:2];
            res_lo = {result[1:0], 6'h00};
        end else begin
            res_hi = {6'h00, result[RES_W-1:8]};
            res_lo = result[7:0];
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `ACS_OFF_RES_LO: next_rdata = res_lo;
                `ACS_OFF_RES_HI: next_rdata = res_hi;
                `ACS_OFF_CTRL_B: next_rdata = {4'h0, ladj, ts};
                `ACS_OFF_CSR:    next_rdata = {en, busy, auto_trig, flag, irq_en, div_sel};
                `ACS_OFF_SEL:    next_rdata = sel_reg;
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // analog side outputs
    // ****************************************
    always_comb begin
        next_ref_route = ref_decode(next_ref_app);
        next_temp_en   = (next_chan_app == `ACS_CH_TEMP);
        next_connect   = (next_chan_app != `ACS_CH_NONE);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            en               <= 1'b0;
            auto_trig        <= 1'b0;
            flag             <= 1'b0;
            irq_en           <= 1'b0;
            div_sel          <= 3'h0;
            sel_reg          <= `ACS_RST_BYTE;
            ladj             <= 1'b0;
            ts               <= 3'h0;
            ref_app          <= 2'h0;
            chan_app         <= 4'h0;
            pend_long        <= 1'b0;
            trig_prev        <= 1'b0;
            lock             <= 1'b0;
            result           <= '0;
            rdata_o          <= 8'h00;
            irq_o            <= 1'b0;
            conv_power_o     <= 1'b0;
            conv_start_o     <= 1'b0;
            long_conv_o      <= 1'b0;
            ref_route_o      <= 3'h1;
            temp_sensor_en_o <= 1'b0;
            chan_connect_o   <= 1'b1;
        end else begin
            en               <= next_en;
            auto_trig        <= next_auto_trig;
            flag             <= next_flag;
            irq_en           <= next_irq_en;
            div_sel          <= next_div_sel;
            sel_reg          <= next_sel_reg;
            ladj             <= next_ladj;
            ts               <= next_ts;
            ref_app          <= next_ref_app;
            chan_app         <= next_chan_app;
            pend_long        <= next_pend_long;
            trig_prev        <= next_trig_prev;
            lock             <= next_lock;
            result           <= next_result;
            rdata_o          <= next_rdata;
            irq_o            <= next_irq;
            conv_power_o     <= next_en;
            conv_start_o     <= fire;
            long_conv_o      <= next_long;
            ref_route_o      <= next_ref_route;
            temp_sensor_en_o <= next_temp_en;
            chan_connect_o   <= next_connect;
        end
    end

    assign ref_sel_o  = ref_app;
    assign chan_sel_o = chan_app;

endmodule : acs_top

/* sim/acs_top_chk.sv */
`timescale 1ns/1ps

module acs_top_chk #(
    parameter int TRIG_N = 7,
    parameter int RES_W  = 10
) (
    input wire logic              mclk_i,
    input wire logic              rst_i,
    input wire logic [2:0]        addr_i,
    input wire logic [7:0]        wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [RES_W-1:0]  conv_result_i,
    input wire logic [TRIG_N-1:0] trig_src_i,
    input wire logic              irq_ack_i,
    input wire logic              global_irq_en_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              irq_o,
    input wire logic              conv_power_o,
    input wire logic              conv_start_o,
    input wire logic              long_conv_o,
    input wire logic              adc_clk_o,
    input wire logic [1:0]        ref_sel_o,
    input wire logic [2:0]        ref_route_o,
    input wire logic [3:0]        chan_sel_o,
    input wire logic              chan_connect_o,
    input wire logic              temp_sensor_en_o
);
    // ****
    // output relations
    // ****
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    temp_route_a: assert property (temp_sensor_en_o == (chan_sel_o == 4'he))
        else $error("sensor enable disagrees with channel");
    ref_decode_a: assert property (ref_route_o == (ref_sel_o == 2'h0 ? 3'h1 : ref_sel_o == 2'h1 ? 3'h2 :
        ref_sel_o == 2'h2 ? 3'h4 : 3'h0))
        else $error("reference route wrong");
    chan_conn_a: assert property (chan_connect_o == (chan_sel_o != 4'hf))
        else $error("channel connect wrong");
    hold_sel_a: assert property (conv_start_o |-> ##2
        (($stable(chan_sel_o) && $stable(ref_sel_o)) || !conv_power_o) [*8])
        else $error("settings changed during conversion");
    power_follow_a: assert property (wr_i && addr_i == 3'h3 |=> conv_power_o == $past(wdata_i[7]))
        else $error("power does not follow enable");
    start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    first_long_a: assert property (wr_i && addr_i == 3'h3 && wdata_i[7:6] == 2'b11 && !conv_power_o
        |=> conv_start_o && long_conv_o)
        else $error("first conversion not long");
    irq_gate_a: assert property (irq_o |-> $past(global_irq_en_i))
        else $error("irq without global enable");
    clk_off_a: assert property (!conv_power_o && !$past(conv_power_o) |-> !adc_clk_o)
        else $error("adc clock runs while disabled");
endmodule : acs_top_chk

bind acs_top acs_top_chk #(.TRIG_N(TRIG_N), .RES_W(RES_W)) chk_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .conv_result_i(conv_result_i), .trig_src_i(trig_src_i), .irq_ack_i(irq_ack_i),
    .global_irq_en_i(global_irq_en_i), .rdata_o(rdata_o), .irq_o(irq_o), .conv_power_o(conv_power_o),
    .conv_start_o(conv_start_o), .long_conv_o(long_conv_o), .adc_clk_o(adc_clk_o), .ref_sel_o(ref_sel_o),
    .ref_route_o(ref_route_o), .chan_sel_o(chan_sel_o), .chan_connect_o(chan_connect_o),
    .temp_sensor_en_o(temp_sensor_en_o));

/* sim/acs_core_model.sv */
`timescale 1ns/1ps

module acs_core_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       power_i,
    input  wire logic [3:0] chan_i,
    input  wire logic [1:0] ref_i,
    output logic      [9:0] result_o
);
    logic flip;
    logic next_flip;

    always_comb begin
        next_flip = ~flip;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flip <= 1'b0;
        end else begin
            flip <= next_flip;
        end
    end

    // unpowered core shows a changing pattern, never a stale value
    assign result_o = power_i ? {chan_i, ref_i, 4'h5} : {10{flip}};
endmodule : acs_core_model

/* sim/tb.sv */
`timescale 1ns/1ps

module tb;
    typedef struct {logic [7:0] d; logic [7:0] m;} acs_exp_t;
    logic       mclk_i, rst_i, wr_i, rd_i, rd_q, irq_ack_i, gie, irq_o, pwr, start, lng, aclk, conn, temp;
    logic [2:0] addr_i, route;
    logic [7:0] wdata_i, rdata_o;
    logic [9:0] res;
    logic [6:0] trig;
    logic [1:0] ref_sel;
    logic [3:0] chan;
    acs_exp_t   q[$];
    acs_exp_t   mx;
    int         fail_count, check_count, n;
    real        t0;

    acs_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .conv_result_i(res), .trig_src_i(trig), .irq_ack_i(irq_ack_i),
        .global_irq_en_i(gie), .rdata_o(rdata_o), .irq_o(irq_o), .conv_power_o(pwr),
        .conv_start_o(start), .long_conv_o(lng), .adc_clk_o(aclk), .ref_sel_o(ref_sel),
        .ref_route_o(route), .chan_sel_o(chan), .chan_connect_o(conn), .temp_sensor_en_o(temp));
    acs_core_model core_u (.mclk_i(mclk_i), .rst_i(rst_i), .power_i(pwr), .chan_i(chan),
        .ref_i(ref_sel), .result_o(res));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // ****
    // tasks
    // ****
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic idle(input int k);
        repeat (k) @(posedge mclk_i);
    endtask : idle

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        q.push_back('{d: e, m: m});
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
    endtask : rd

    task automatic wait_irq(output int c);
        c = 0;
        while (irq_o !== 1'b1 && c < 400) begin
            @(posedge mclk_i);
            c++;
        end
        if (c >= 400) begin
            fail_count++;
        end
    endtask : wait_irq

    task automatic wait_start(output int c);
        c = 0;
        while (start !== 1'b1 && c < 50) begin
            @(posedge mclk_i);
            c++;
        end
        if (c >= 50) begin
            fail_count++;
        end
    endtask : wait_start

    task automatic conv(input logic [7:0] c, output int k);
        wr(3'h3, c);
        wait_irq(k);
    endtask : conv

    // read results are compared one cycle after the read strobe
    always @(posedge mclk_i) begin
        rd_q <= rd_i;
        if (rd_q === 1'b1) begin
            mx = q.pop_front();
            check(rdata_o & mx.m, mx.d & mx.m);
        end
    end

    initial begin
        #(40000 * 5);
        fail_count++;
        tally_and_finish();
    end

    // ****
    // scenarios
    // ****
    initial begin
        void'($urandom(32'hdf4b));
        {wr_i, rd_i, irq_ack_i, gie, addr_i, wdata_i, trig} = '0;
        rst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        check(8'(route), 8'h01);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), 8'h00, 8'hff);
        end
        for (int i = 0; i < 16; i++) begin
            wr(3'h4, {2'(i), 2'b00, 4'(i)});
            idle(2);
            check(8'(chan), 8'(i));
            check(8'(conn), 8'(i != 15));
            check(8'(temp), 8'(i == 14));
            check(8'(route), 8'(i % 4 == 3 ? 0 : 1 << (i % 4)));
            rd(3'h4, {2'(i), 2'b00, 4'(i)}, 8'hff);
        end
        for (int p = 0; p < 8; p++) begin
            wr(3'h3, 8'h80 | 8'(p));
            repeat (2) @(posedge aclk);
            t0 = $realtime;
            @(posedge aclk);
            check(8'(int'(($realtime - t0) / 5.0)), 8'(p < 2 ? 2 : 1 << p));
        end
        wr(3'h3, 8'h00);
        idle(3);
        check(8'(aclk), 8'h00);
        gie <= 1'b1;
        wr(3'h4, 8'h8e);
        conv(8'hc9, n);
        check(8'(n >= 49 && n <= 57), 8'h01);
        check(8'(lng), 8'h01);
        rd(3'h3, 8'h99, 8'hff);
        rd(3'h0, 8'ha5, 8'hff);
        rd(3'h1, 8'h03, 8'hff);
        wr(3'h3, 8'h99);
        rd(3'h3, 8'h89, 8'hff);
        check(8'(irq_o), 8'h00);
        conv(8'hc9, n);
        check(8'(n >= 25 && n <= 33), 8'h01);
        irq_ack_i <= 1'b1;
        @(posedge mclk_i);
        irq_ack_i <= 1'b0;
        rd(3'h3, 8'h89, 8'hff);
        gie <= 1'b0;
        wr(3'h3, 8'hc9);
        idle(70);
        check(8'(irq_o), 8'h00);
        rd(3'h3, 8'h99, 8'hff);
        gie <= 1'b1;
        idle(3);
        check(8'(irq_o), 8'h01);
        wr(3'h3, 8'h99);
        wr(3'h3, 8'hc9);
        idle(6);
        wr(3'h4, 8'h43);
        check(8'(chan), 8'h0e);
        check(8'(ref_sel), 8'h02);
        wait_irq(n);
        idle(2);
        check(8'(chan), 8'h03);
        rd(3'h0, 8'ha5, 8'hff);
        rd(3'h1, 8'h03, 8'hff);
        wr(3'h3, 8'h99);
        conv(8'hc9, n);
        check(8'(n >= 49 && n <= 57), 8'h01);
        wr(3'h2, 8'h08);
        rd(3'h0, 8'h40, 8'hff);
        rd(3'h1, 8'h35, 8'hff);
        wr(3'h3, 8'h99);
        rd(3'h0, 8'h40, 8'hff);
        wr(3'h4, 8'h45);
        conv(8'hc9, n);
        rd(3'h1, 8'h35, 8'hff);
        wr(3'h2, 8'h00);
        rd(3'h0, 8'hd5, 8'hff);
        wr(3'h3, 8'h99);
        wr(3'h3, 8'hc9);
        idle(12);
        wr(3'h3, 8'h09);
        idle(80);
        rd(3'h3, 8'h09, 8'hff);
        wr(3'h4, 8'h8e);
        conv(8'hc9, n);
        check(8'(n >= 49 && n <= 57), 8'h01);
        wr(3'h3, 8'h99);
        for (int k = 1; k < 8; k++) begin
            trig <= 7'($urandom) & ~(7'h01 << (k - 1));
            wr(3'h2, 8'(k));
            wr(3'h3, 8'hb9);
            trig <= trig | (7'h01 << (k - 1));
            wait_start(n);
            check(8'(n < 6), 8'h01);
            wait_irq(n);
            wr(3'h3, 8'h99);
        end
        wr(3'h2, 8'h00);
        wr(3'h3, 8'he9);
        n = 0;
        repeat (150) begin
            @(posedge mclk_i);
            n += int'(start === 1'b1);
        end
        check(8'(n >= 3), 8'h01);
        wr(3'h3, 8'h10);
        idle(4);
        tally_and_finish();
    end
endmodule : tb
